// File: pkg/mcfe_map.svh
// Purpose: Register map, field positions and reset values of the MAC configuration bank
// Assumes: Word indices are the printed offsets; the byte address is four times the index
// Notes: Definitions only
`ifndef MCFE_MAP_SVH
`define MCFE_MAP_SVH

`define MCFE_IDX_W 10
`define MCFE_IDX_RMS 10'h0da
`define MCFE_IDX_CFG3 10'h0d4
`define MCFE_IDX_CMD 10'h0e0
`define MCFE_IDX_RING_LO 10'h0e4
`define MCFE_IDX_RING_HI 10'h0e8
`define MCFE_IDX_ETT 10'h0ec
`define MCFE_IDX_FEV 10'h0f0
`define MCFE_IDX_FEM 10'h0f4
`define MCFE_IDX_FPS 10'h0f8
`define MCFE_IDX_FORCE 10'h0fc

`define MCFE_RMS_W 14
`define MCFE_ETT_W 6
`define MCFE_ETT_UNIT_SHIFT 5

`define MCFE_CMD_ENDIAN 9
`define MCFE_CMD_TAG_STRIP 6
`define MCFE_CMD_SUM 5
`define MCFE_CMD_DAC 4
`define MCFE_CMD_MULTI 3
`define MCFE_CMD_WMASK 16'h0278

`define MCFE_FE_FUNCTION_INTERRUPT_FLAG 15
`define MCFE_FE_WAKE_MASK 14
`define MCFE_FE_GENERAL_WAKE_FLAG 4
`define MCFE_FEM_WMASK 16'hc010

`define MCFE_CFG3_CARD_EN 3
`define MCFE_CFG3_FUNC_ON 1
`define MCFE_CFG3_WMASK 8'h0a

`define MCFE_RMS_RST 14'h0000
`define MCFE_CMD_RST 16'h0000
`define MCFE_RING_RST 64'h0000000000000000
`define MCFE_ETT_RST 6'h08
`define MCFE_FEM_RST 16'h0000
`define MCFE_CFG3_RST 8'h00

`define MCFE_RESP_OKAY 2'h0
`define MCFE_RESP_SLVERR 2'h2

`endif

// File: pkg/mcfe_pkg.sv
// Purpose: Types shared by the MAC configuration bank
// Assumes: Nothing
// Notes: Constants live in mcfe_map.svh
package mcfe_pkg;
  typedef enum logic [0:0] {WR_IDLE, WR_RESP} mcfe_wr_state_e;
  typedef enum logic [0:0] {RD_IDLE, RD_RESP} mcfe_rd_state_e;
  typedef logic [1:0] mcfe_resp_t;
endpackage

// File: rtl/mcfe_sticky_flag.sv
// Purpose: Sticky event flag, set by hardware, cleared by write-one
// Assumes: Set and clear are one-cycle pulses on the local clock
// Notes: Of the resets, only the power-on reset clears it
`timescale 1ns/1ps
`default_nettype none
module mcfe_sticky_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic flag_q
);
  logic flag_next;

  // Set wins so an event in the clearing cycle is never lost
  assign flag_next = set_pulse | (flag_q & ~clr_pulse);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_next;
  end

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n) set_pulse |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag missed a set");

  property p_clear;
    @(posedge clk) disable iff (!rst_n) (clr_pulse && !set_pulse) |=> !flag_q;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_hold;
    @(posedge clk) disable iff (!rst_n) (!set_pulse && !clr_pulse) |=> (flag_q == $past(flag_q));
  endproperty
  a_hold: assert property (p_hold) else $error("flag changed without cause");
endmodule
`default_nettype wire

// File: rtl/mcfe_early_send.sv
// Purpose: Start-of-transmit decision from the transmit FIFO fill level
// Assumes: FIFO byte count and complete-packet flag are synchronous
// Notes: A reserved zero level leaves only the complete-packet trigger
`include "mcfe_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mcfe_early_send #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`MCFE_ETT_W-1:0] level,
  input wire logic [CNT_W-1:0] fifo_bytes,
  input wire logic full_pkt,
  output logic start_q
);
  logic [CNT_W-1:0] thr_bytes;
  logic level_ok;
  logic start_next;

  assign thr_bytes = CNT_W'({level, 5'h00});
  assign level_ok = (level != 6'h00);
  assign start_next = full_pkt | (level_ok & (fifo_bytes >= thr_bytes));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      start_q <= 1'b0;
    else
      start_q <= start_next;
  end

  property p_full_pkt;
    @(posedge clk) disable iff (!rst_n) full_pkt |=> start_q;
  endproperty
  a_full_pkt: assert property (p_full_pkt) else $error("complete packet did not start transmit");

  property p_level;
    @(posedge clk) disable iff (!rst_n)
      !full_pkt |=> (start_q == ($past(level) != 6'h00 && $past(fifo_bytes) >= CNT_W'({$past(level), 5'h00})));
  endproperty
  a_level: assert property (p_level) else $error("threshold start wrong");
endmodule
`default_nettype wire

// File: rtl/mcfe_regs.sv
// Purpose: AXI4-Lite configuration and function-event registers of the Ethernet MAC
// Assumes: All non-bus inputs are synchronous to SYS_CLK; RST_N is the power-on reset
// Notes: BUS_RESET and SOFT_RESET load the reset values into the size, command, ring and threshold (08h) words but leave event state, event mask and CFG3 alone
// Functional notes
// - Receive size field is 14 bits wide
// - Command bit 6 enables VLAN tag stripping
// - Command bit 5 enables receive checksum offload
// - Dual cycle only for nonzero upper address
// - Multiple read/write overrides DMA burst limits
// - Command register takes only 16-bit writes
// - Ring base low at E4h, high E8h
// - Transmit starts at threshold or full packet
// - Threshold counts in 32-byte units
// - Forced interrupt sets flag; write-one clears
// - Interrupt flag survives bus and soft reset
// - Wake flag sets on rising present wake
// - Function registers valid only when both enabled
// - Flags drive wake pin, active high
// - Cleared wake mask blocks the wake pin
`include "mcfe_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mcfe_regs #(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 16
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic BUS_RESET,
  input wire logic SOFT_RESET,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic PRESENT_FUNCTION_INTERRUPT_FLAG,
  input wire logic PRESENT_WAKE,
  input wire logic [CNT_W-1:0] TX_FIFO_BYTES,
  input wire logic TX_FIFO_FULL_PKT,
  output logic TX_START,
  input wire logic [31:0] DMA_ADDR_HI,
  output logic DMA_DUAL_CYCLE,
  output logic [`MCFE_RMS_W-1:0] RX_MAX_SIZE,
  output logic RX_ACCEPT_EN,
  output logic BIG_ENDIAN,
  output logic RX_TAG_STRIP_EN,
  output logic RX_SUM_OFFLOAD_EN,
  output logic DAC_EN,
  output logic MULTI_READ_WRITE_EN,
  output logic DMA_BURST_LIMIT_EN,
  output logic [63:0] RX_RING_BASE,
  output logic [`MCFE_ETT_W-1:0] EARLY_SEND_LEVEL,
  output logic CARD_STATUS_CHANGE_PIN
);
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  mcfe_pkg::mcfe_wr_state_e wr_state_reg;
  mcfe_pkg::mcfe_wr_state_e wr_state_next;
  mcfe_pkg::mcfe_rd_state_e rd_state_reg;
  mcfe_pkg::mcfe_rd_state_e rd_state_next;
  mcfe_pkg::mcfe_resp_t b_resp_reg;
  mcfe_pkg::mcfe_resp_t r_resp_reg;
  logic [31:0] r_data_reg;
  logic [`MCFE_RMS_W-1:0] rms_reg;
  logic [15:0] cmd_reg;
  logic [63:0] ring_reg;
  logic [`MCFE_ETT_W-1:0] ett_reg;
  logic [15:0] fem_reg;
  logic [7:0] cfg3_reg;
  logic pwake_d_reg;
  logic dual_reg;
  logic pin_reg;
  logic pin_next;
  logic function_interrupt_flag_flag;
  logic general_wake_flag_flag;

  function automatic logic [`MCFE_IDX_W-1:0] word_index(input logic [ADDR_W-1:0] a);
    return `MCFE_IDX_W'(a >> 2);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        m[i*8 +: 8] = new_v[i*8 +: 8];
    return m;
  endfunction

  function automatic logic [31:0] flag_word(input logic function_interrupt_flag, input logic general_wake_flag);
    logic [31:0] w;
    w = 32'h00000000;
    w[`MCFE_FE_FUNCTION_INTERRUPT_FLAG] = function_interrupt_flag;
    w[`MCFE_FE_GENERAL_WAKE_FLAG] = general_wake_flag;
    return w;
  endfunction

  // Write channel: address and data are parked separately so either may come first
  logic aw_fire, w_fire, ar_fire, b_fire, r_fire, do_write, cfg_clr, func_valid;
  logic [`MCFE_IDX_W-1:0] wr_idx, rd_idx;
  logic wr_rms, wr_cmd, wr_rlo, wr_rhi, wr_ett, wr_fev, wr_fem, wr_frc, wr_cfg3, wr_hit;
  logic rd_rms, rd_cmd, rd_rlo, rd_rhi, rd_ett, rd_fev, rd_fem, rd_fps, rd_frc, rd_cfg3, rd_hit;
  logic cmd_word_ok, function_interrupt_flag_set, function_interrupt_flag_clr, general_wake_flag_set, general_wake_flag_clr;
  logic [31:0] rms_m, rlo_m, rhi_m, ett_m, fem_m, cfg3_m, rd_word;

  assign S_AXI_AWREADY = (wr_state_reg == mcfe_pkg::WR_IDLE) & ~aw_held_reg;
  assign S_AXI_WREADY = (wr_state_reg == mcfe_pkg::WR_IDLE) & ~w_held_reg;
  assign S_AXI_BVALID = (wr_state_reg == mcfe_pkg::WR_RESP);
  assign S_AXI_BRESP = b_resp_reg;
  assign S_AXI_ARREADY = (rd_state_reg == mcfe_pkg::RD_IDLE);
  assign S_AXI_RVALID = (rd_state_reg == mcfe_pkg::RD_RESP);
  assign S_AXI_RRESP = r_resp_reg;
  assign S_AXI_RDATA = r_data_reg;
  assign aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_fire = S_AXI_WVALID & S_AXI_WREADY;
  assign ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
  assign b_fire = S_AXI_BVALID & S_AXI_BREADY;
  assign r_fire = S_AXI_RVALID & S_AXI_RREADY;
  assign do_write = (wr_state_reg == mcfe_pkg::WR_IDLE) & aw_held_reg & w_held_reg;
  assign cfg_clr = BUS_RESET | SOFT_RESET;
  assign func_valid = cfg3_reg[`MCFE_CFG3_CARD_EN] & cfg3_reg[`MCFE_CFG3_FUNC_ON];

  assign wr_idx = word_index(aw_addr_reg);
  assign wr_rms = do_write & (wr_idx == `MCFE_IDX_RMS);
  assign wr_cmd = do_write & (wr_idx == `MCFE_IDX_CMD);
  assign wr_rlo = do_write & (wr_idx == `MCFE_IDX_RING_LO);
  assign wr_rhi = do_write & (wr_idx == `MCFE_IDX_RING_HI);
  assign wr_ett = do_write & (wr_idx == `MCFE_IDX_ETT);
  assign wr_fev = do_write & (wr_idx == `MCFE_IDX_FEV) & func_valid;
  assign wr_fem = do_write & (wr_idx == `MCFE_IDX_FEM) & func_valid;
  assign wr_frc = do_write & (wr_idx == `MCFE_IDX_FORCE) & func_valid;
  assign wr_cfg3 = do_write & (wr_idx == `MCFE_IDX_CFG3);
  assign wr_hit = (wr_idx == `MCFE_IDX_RMS) | (wr_idx == `MCFE_IDX_CMD) | (wr_idx == `MCFE_IDX_RING_LO) |
                  (wr_idx == `MCFE_IDX_RING_HI) | (wr_idx == `MCFE_IDX_ETT) | (wr_idx == `MCFE_IDX_FEV) |
                  (wr_idx == `MCFE_IDX_FEM) | (wr_idx == `MCFE_IDX_FPS) | (wr_idx == `MCFE_IDX_FORCE) |
                  (wr_idx == `MCFE_IDX_CFG3);
  // Byte or odd-lane writes to the command word are acknowledged but dropped
  assign cmd_word_ok = (w_strb_reg[1:0] == 2'h3);

  assign rms_m = merge({18'h00000, rms_reg}, w_data_reg, w_strb_reg);
  assign rlo_m = merge(ring_reg[31:0], w_data_reg, w_strb_reg);
  assign rhi_m = merge(ring_reg[63:32], w_data_reg, w_strb_reg);
  assign ett_m = merge({26'h0000000, ett_reg}, w_data_reg, w_strb_reg);
  assign fem_m = merge({16'h0000, fem_reg}, w_data_reg, w_strb_reg);
  assign cfg3_m = merge({24'h000000, cfg3_reg}, w_data_reg, w_strb_reg);

  assign function_interrupt_flag_set = wr_frc & w_strb_reg[1] & w_data_reg[`MCFE_FE_FUNCTION_INTERRUPT_FLAG];
  assign function_interrupt_flag_clr = wr_fev & w_strb_reg[1] & w_data_reg[`MCFE_FE_FUNCTION_INTERRUPT_FLAG];
  assign general_wake_flag_set = (PRESENT_WAKE & ~pwake_d_reg) | (wr_frc & w_strb_reg[0] & w_data_reg[`MCFE_FE_GENERAL_WAKE_FLAG]);
  assign general_wake_flag_clr = wr_fev & w_strb_reg[0] & w_data_reg[`MCFE_FE_GENERAL_WAKE_FLAG];

  assign rd_idx = word_index(S_AXI_ARADDR);
  assign rd_rms = (rd_idx == `MCFE_IDX_RMS);
  assign rd_cmd = (rd_idx == `MCFE_IDX_CMD);
  assign rd_rlo = (rd_idx == `MCFE_IDX_RING_LO);
  assign rd_rhi = (rd_idx == `MCFE_IDX_RING_HI);
  assign rd_ett = (rd_idx == `MCFE_IDX_ETT);
  assign rd_fev = (rd_idx == `MCFE_IDX_FEV);
  assign rd_fem = (rd_idx == `MCFE_IDX_FEM);
  assign rd_fps = (rd_idx == `MCFE_IDX_FPS);
  assign rd_frc = (rd_idx == `MCFE_IDX_FORCE);
  assign rd_cfg3 = (rd_idx == `MCFE_IDX_CFG3);
  assign rd_hit = rd_rms | rd_cmd | rd_rlo | rd_rhi | rd_ett | rd_fev | rd_fem | rd_fps | rd_frc | rd_cfg3;
  // Function-event words read as zero while the function registers are off
  assign rd_word = rd_rms ? {18'h00000, rms_reg} :
                   rd_cmd ? {16'h0000, cmd_reg} :
                   rd_rlo ? ring_reg[31:0] :
                   rd_rhi ? ring_reg[63:32] :
                   rd_ett ? {26'h0000000, ett_reg} :
                   (rd_fev & func_valid) ? flag_word(function_interrupt_flag_flag, general_wake_flag_flag) :
                   (rd_fem & func_valid) ? {16'h0000, fem_reg} :
                   (rd_fps & func_valid) ? flag_word(PRESENT_FUNCTION_INTERRUPT_FLAG, PRESENT_WAKE) :
                   rd_cfg3 ? {24'h000000, cfg3_reg} : 32'h00000000;

  always_comb
  begin
    case (wr_state_reg)
      mcfe_pkg::WR_IDLE: wr_state_next = do_write ? mcfe_pkg::WR_RESP : mcfe_pkg::WR_IDLE;
      mcfe_pkg::WR_RESP: wr_state_next = S_AXI_BREADY ? mcfe_pkg::WR_IDLE : mcfe_pkg::WR_RESP;
      default: wr_state_next = mcfe_pkg::WR_IDLE;
    endcase
    case (rd_state_reg)
      mcfe_pkg::RD_IDLE: rd_state_next = S_AXI_ARVALID ? mcfe_pkg::RD_RESP : mcfe_pkg::RD_IDLE;
      mcfe_pkg::RD_RESP: rd_state_next = S_AXI_RREADY ? mcfe_pkg::RD_IDLE : mcfe_pkg::RD_RESP;
      default: rd_state_next = mcfe_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_state_reg <= mcfe_pkg::WR_IDLE;
      rd_state_reg <= mcfe_pkg::RD_IDLE;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end
    else
    begin
      wr_state_reg <= wr_state_next;
      rd_state_reg <= rd_state_next;
      aw_held_reg <= aw_fire | (aw_held_reg & ~b_fire);
      w_held_reg <= w_fire | (w_held_reg & ~b_fire);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_addr_reg <= '0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      b_resp_reg <= `MCFE_RESP_OKAY;
      r_resp_reg <= `MCFE_RESP_OKAY;
      r_data_reg <= 32'h00000000;
    end
    else
    begin
      if (aw_fire)
        aw_addr_reg <= S_AXI_AWADDR;
      if (w_fire)
        w_data_reg <= S_AXI_WDATA;
      if (w_fire)
        w_strb_reg <= S_AXI_WSTRB;
      if (do_write)
        b_resp_reg <= wr_hit ? `MCFE_RESP_OKAY : `MCFE_RESP_SLVERR;
      if (ar_fire)
        r_resp_reg <= rd_hit ? `MCFE_RESP_OKAY : `MCFE_RESP_SLVERR;
      if (ar_fire)
        r_data_reg <= rd_word;
    end
  end

  // Configuration words follow the bus and software resets
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rms_reg <= `MCFE_RMS_RST;
      cmd_reg <= `MCFE_CMD_RST;
      ring_reg <= `MCFE_RING_RST;
      ett_reg <= `MCFE_ETT_RST;
    end
    else if (cfg_clr)
    begin
      rms_reg <= `MCFE_RMS_RST;
      cmd_reg <= `MCFE_CMD_RST;
      ring_reg <= `MCFE_RING_RST;
      ett_reg <= `MCFE_ETT_RST;
    end
    else
    begin
      if (wr_rms)
        rms_reg <= rms_m[`MCFE_RMS_W-1:0];
      if (wr_cmd & cmd_word_ok)
        cmd_reg <= w_data_reg[15:0] & `MCFE_CMD_WMASK;
      if (wr_rlo)
        ring_reg[31:0] <= rlo_m;
      if (wr_rhi)
        ring_reg[63:32] <= rhi_m;
      if (wr_ett)
        ett_reg <= ett_m[`MCFE_ETT_W-1:0];
    end
  end

  // Event state only follows the power-on reset
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      fem_reg <= `MCFE_FEM_RST;
      cfg3_reg <= `MCFE_CFG3_RST;
      pwake_d_reg <= 1'b0;
      dual_reg <= 1'b0;
      pin_reg <= 1'b0;
    end
    else
    begin
      if (wr_fem)
        fem_reg <= fem_m[15:0] & `MCFE_FEM_WMASK;
      if (wr_cfg3)
        cfg3_reg <= cfg3_m[7:0] & `MCFE_CFG3_WMASK;
      pwake_d_reg <= PRESENT_WAKE;
      dual_reg <= cmd_reg[`MCFE_CMD_DAC] & (DMA_ADDR_HI != 32'h00000000);
      pin_reg <= pin_next;
    end
  end

  assign pin_next = func_valid & fem_reg[`MCFE_FE_WAKE_MASK] &
                    ((function_interrupt_flag_flag & fem_reg[`MCFE_FE_FUNCTION_INTERRUPT_FLAG]) | (general_wake_flag_flag & fem_reg[`MCFE_FE_GENERAL_WAKE_FLAG]));

  mcfe_sticky_flag u_function_interrupt_flag_flag (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .set_pulse(function_interrupt_flag_set),
    .clr_pulse(function_interrupt_flag_clr),
    .flag_q(function_interrupt_flag_flag)
  );

  mcfe_sticky_flag u_general_wake_flag_flag (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .set_pulse(general_wake_flag_set),
    .clr_pulse(general_wake_flag_clr),
    .flag_q(general_wake_flag_flag)
  );

  mcfe_early_send #(.CNT_W(CNT_W)) u_early_send (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .level(ett_reg),
    .fifo_bytes(TX_FIFO_BYTES),
    .full_pkt(TX_FIFO_FULL_PKT),
    .start_q(TX_START)
  );

  assign RX_MAX_SIZE = rms_reg;
  assign RX_ACCEPT_EN = (rms_reg != 14'h0000);
  assign BIG_ENDIAN = cmd_reg[`MCFE_CMD_ENDIAN];
  assign RX_TAG_STRIP_EN = cmd_reg[`MCFE_CMD_TAG_STRIP];
  assign RX_SUM_OFFLOAD_EN = cmd_reg[`MCFE_CMD_SUM];
  assign DAC_EN = cmd_reg[`MCFE_CMD_DAC];
  assign MULTI_READ_WRITE_EN = cmd_reg[`MCFE_CMD_MULTI];
  assign DMA_BURST_LIMIT_EN = ~cmd_reg[`MCFE_CMD_MULTI];
  assign DMA_DUAL_CYCLE = dual_reg;
  assign RX_RING_BASE = ring_reg;
  assign EARLY_SEND_LEVEL = ett_reg;
  assign CARD_STATUS_CHANGE_PIN = pin_reg;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_cmd_write;
    wr_cmd && !cfg_clr;
  endsequence

  property p_cmd_byte_ignored;
    s_cmd_write ##0 !cmd_word_ok |=> $stable(cmd_reg);
  endproperty
  a_cmd_byte_ignored: assert property (p_cmd_byte_ignored) else $error("byte write changed command");

  property p_endian;
    s_cmd_write ##0 cmd_word_ok |=> BIG_ENDIAN == $past(w_data_reg[`MCFE_CMD_ENDIAN]);
  endproperty
  a_endian: assert property (p_endian) else $error("endian bit not taken");

  property p_offload;
    s_cmd_write ##0 cmd_word_ok |=> (RX_TAG_STRIP_EN == $past(w_data_reg[`MCFE_CMD_TAG_STRIP])) &&
                                    (RX_SUM_OFFLOAD_EN == $past(w_data_reg[`MCFE_CMD_SUM]));
  endproperty
  a_offload: assert property (p_offload) else $error("offload enables not taken");

  property p_burst;
    s_cmd_write ##0 cmd_word_ok |=> (DMA_BURST_LIMIT_EN == !$past(w_data_reg[`MCFE_CMD_MULTI])) &&
                                    (MULTI_READ_WRITE_EN == $past(w_data_reg[`MCFE_CMD_MULTI]));
  endproperty
  a_burst: assert property (p_burst) else $error("burst limit not overridden");

  property p_dual;
    1'b1 |=> DMA_DUAL_CYCLE == ($past(DAC_EN) && ($past(DMA_ADDR_HI) != 32'h00000000));
  endproperty
  a_dual: assert property (p_dual) else $error("dual cycle decision wrong");

  property p_rms;
    wr_rms && !cfg_clr && w_strb_reg[1:0] == 2'h3 |=> RX_MAX_SIZE == $past(w_data_reg[13:0]);
  endproperty
  a_rms: assert property (p_rms) else $error("size field not stored");

  property p_ring_hi;
    wr_rhi && !cfg_clr && w_strb_reg == 4'hf |=> RX_RING_BASE[63:32] == $past(w_data_reg);
  endproperty
  a_ring_hi: assert property (p_ring_hi) else $error("ring base high word not stored");

  property p_wake_mask;
    !fem_reg[`MCFE_FE_WAKE_MASK] || !func_valid |=> !CARD_STATUS_CHANGE_PIN;
  endproperty
  a_wake_mask: assert property (p_wake_mask) else $error("wake pin raised while masked");

  sequence s_function_interrupt_flag_armed;
    func_valid && fem_reg[`MCFE_FE_WAKE_MASK] && fem_reg[`MCFE_FE_FUNCTION_INTERRUPT_FLAG] && function_interrupt_flag_flag;
  endsequence

  property p_wake_drive;
    s_function_interrupt_flag_armed |=> CARD_STATUS_CHANGE_PIN;
  endproperty
  a_wake_drive: assert property (p_wake_drive) else $error("wake pin not raised");

  property p_write_resp;
    do_write |=> S_AXI_BVALID && (S_AXI_BRESP == ($past(wr_hit) ? `MCFE_RESP_OKAY : `MCFE_RESP_SLVERR));
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response wrong");
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the MAC configuration and function event registers
// Assumes: Map and reset values of mcfe_map.svh; byte address is four times the word index
// Notes: Random data from a fixed-seed LFSR; property checks live in the design files
`include "mcfe_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic bus_rst = 1'b0;
  logic soft_rst = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic p_wake = 1'b0;
  logic p_function_interrupt_flag = 1'b0;
  logic full_pkt = 1'b0;
  logic [15:0] fifo_b = '0;
  logic [31:0] addr_hi = '0;
  logic awready, wready, bvalid, arready, rvalid, tx_start, dual, acc_en;
  logic big_e, strip, sum, dac, multi, burst, pin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [13:0] rx_max;
  logic [63:0] ring;
  logic [5:0] lvl;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [15:0] lf = 16'h598f;
  logic [31:0] r;
  logic [5:0] code;

  always #2.5 clk = ~clk;

  mcfe_regs mcfe_regs_inst (.SYS_CLK(clk), .RST_N(rst_n), .BUS_RESET(bus_rst), .SOFT_RESET(soft_rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .PRESENT_FUNCTION_INTERRUPT_FLAG(p_function_interrupt_flag), .PRESENT_WAKE(p_wake), .TX_FIFO_BYTES(fifo_b),
    .TX_FIFO_FULL_PKT(full_pkt), .TX_START(tx_start), .DMA_ADDR_HI(addr_hi), .DMA_DUAL_CYCLE(dual),
    .RX_MAX_SIZE(rx_max), .RX_ACCEPT_EN(acc_en), .BIG_ENDIAN(big_e), .RX_TAG_STRIP_EN(strip),
    .RX_SUM_OFFLOAD_EN(sum), .DAC_EN(dac), .MULTI_READ_WRITE_EN(multi), .DMA_BURST_LIMIT_EN(burst),
    .RX_RING_BASE(ring), .EARLY_SEND_LEVEL(lvl), .CARD_STATUS_CHANGE_PIN(pin));

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic wrap_up;
    $display("Counts: checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Valids are dropped only at the edge that takes them; bready stays up until the answer
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, ed);
    check(32'(rresp), 32'(er));
  endtask

  // Settle time for the one-cycle-late outputs
  task automatic wait2;
    repeat (2) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(12'h368, 32'h0, 2'h0);
    check(32'(acc_en), 32'h0);
    axi_rd(12'h380, 32'h0, 2'h0);
    axi_rd(12'h3b0, 32'h8, 2'h0);
    $display("test reset values done");
    repeat (4)
    begin
      lf = lfsr_next(lf);
      r[31:16] = lf;
      lf = lfsr_next(lf);
      r[15:0] = lf;
      code = (r[5:0] == 6'h00) ? 6'h01 : r[5:0];
      axi_wr(12'h380, r, 4'hf, 2'h0);
      axi_rd(12'h380, r & 32'h278, 2'h0);
      check({big_e, strip, sum, dac, multi, burst}, {r[9], r[6], r[5], r[4], r[3], ~r[3]});
      axi_wr(12'h380, ~r, 4'h1, 2'h0);
      axi_rd(12'h380, r & 32'h278, 2'h0);
      axi_wr(12'h368, r, 4'hf, 2'h0);
      axi_rd(12'h368, r & 32'h3fff, 2'h0);
      check({rx_max, acc_en}, {r[13:0], r[13:0] != 14'h0});
      axi_wr(12'h390, {r[31:8], 8'h00}, 4'hf, 2'h0);
      axi_wr(12'h3a0, ~r, 4'hf, 2'h0);
      axi_rd(12'h390, {r[31:8], 8'h00}, 2'h0);
      axi_rd(12'h3a0, ~r, 2'h0);
      check(ring[31:0], {r[31:8], 8'h00});
      check(ring[63:32], ~r);
      axi_wr(12'h3b0, 32'(code), 4'hf, 2'h0);
      axi_rd(12'h3b0, 32'(code), 2'h0);
      check(32'(lvl), 32'(code));
      fifo_b <= 16'(code) * 16'd32 - 16'd1;
      wait2();
      check(32'(tx_start), 32'h0);
      fifo_b <= 16'(code) * 16'd32;
      wait2();
      check(32'(tx_start), 32'h1);
      fifo_b <= 16'h0;
      full_pkt <= 1'b1;
      wait2();
      check(32'(tx_start), 32'h1);
      full_pkt <= 1'b0;
      addr_hi <= 32'h0;
      wait2();
      check(32'(dual), 32'h0);
      addr_hi <= r;
      wait2();
      check(32'(dual), 32'(r[4] && r != 32'h0));
    end
    $display("test random config done");
    axi_wr(12'h004, r, 4'hf, 2'h2);
    axi_rd(12'h004, 32'h0, 2'h2);
    axi_wr(12'h350, 32'h0a, 4'hf, 2'h0);
    axi_wr(12'h3d0, 32'hc010, 4'hf, 2'h0);
    axi_wr(12'h3f0, 32'h8000, 4'hf, 2'h0);
    axi_rd(12'h3c0, 32'h8000, 2'h0);
    wait2();
    check(32'(pin), 32'h1);
    axi_wr(12'h3c0, 32'h0, 4'hf, 2'h0);
    axi_rd(12'h3c0, 32'h8000, 2'h0);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    axi_rd(12'h3c0, 32'h8000, 2'h0);
    axi_rd(12'h380, 32'h0, 2'h0);
    axi_wr(12'h3c0, 32'h8000, 4'hf, 2'h0);
    axi_rd(12'h3c0, 32'h0, 2'h0);
    wait2();
    check(32'(pin), 32'h0);
    p_wake <= 1'b1;
    p_function_interrupt_flag <= 1'b1;
    repeat (3) @(posedge clk);
    axi_rd(12'h3c0, 32'h10, 2'h0);
    axi_rd(12'h3e0, 32'h8010, 2'h0);
    check(32'(pin), 32'h1);
    axi_wr(12'h3d0, 32'h8010, 4'hf, 2'h0);
    axi_rd(12'h3d0, 32'h8010, 2'h0);
    wait2();
    check(32'(pin), 32'h0);
    axi_wr(12'h350, 32'h08, 4'hf, 2'h0);
    axi_rd(12'h3c0, 32'h0, 2'h0);
    axi_wr(12'h350, 32'h0a, 4'hf, 2'h0);
    axi_rd(12'h3c0, 32'h10, 2'h0);
    axi_wr(12'h3c0, 32'h10, 4'hf, 2'h0);
    axi_rd(12'h3c0, 32'h0, 2'h0);
    $display("test function events done");
    wrap_up();
  end
endmodule
`default_nettype wire
